// [src/hfd_pkg.sv]
`default_nettype none
package hfd_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h0B;
  localparam logic [7:0] ADDR_FIRE = 8'h0C;
  localparam logic [7:0] ADDR_RATED = 8'h16;
  localparam logic [7:0] ADDR_CLAMP = 8'h17;
  localparam logic [7:0] ADDR_DRIVE_TIME = 8'h1B;
  localparam logic [7:0] ADDR_SENSE_TIME = 8'h1C;
  localparam logic [7:0] ADDR_LOOP_CFG = 8'h1D;
  localparam logic [7:0] ADDR_OL_PERIOD = 8'h20;
  // Field positions
  localparam int POS_BLANK = 4;
  localparam int POS_OPEN_LOOP = 5;
  localparam int POS_LRA = 7;
  localparam int POS_BUSY = 1;
  // Values after reset
  localparam logic [7:0] RST_RATED = 8'h3F;
  localparam logic [7:0] RST_CLAMP = 8'h8C;
  localparam logic [4:0] RST_DRIVE_TIME = 5'h13;
  localparam logic [3:0] RST_IDISS = 4'h1;
  localparam logic [3:0] RST_BLANK = 4'h1;
  localparam logic [1:0] RST_ZC = 2'h1;
  localparam logic [6:0] RST_OL_PERIOD = 7'h32;
  // Timing: one tick is the unit of every timing field
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int EFFECT_MS = 50;
  localparam int EFFECT_TICKS = EFFECT_MS * 1000 / TICK_US;
  localparam int OD_MS = 2;
  localparam int OD_TICKS = OD_MS * 1000 / TICK_US;
  localparam int PROC_MS = 100;
  localparam int PROC_TICKS = PROC_MS * 1000 / TICK_US;
  localparam int ZC_WIN_US = 1000;
  localparam int ZC_WIN_TICKS = ZC_WIN_US / TICK_US;

  typedef enum logic [2:0] {
    MODE_INT_TRIG = 3'h0, MODE_EDGE_TRIG = 3'h1, MODE_LEVEL_TRIG = 3'h2,
    MODE_ANALOG_PWM = 3'h3, MODE_AUDIO_VIBE = 3'h4, MODE_REALTIME = 3'h5,
    MODE_DIAG = 3'h6, MODE_CAL = 3'h7
  } hfd_mode_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'h0, P_LOAD = 3'h1, P_PLAY = 3'h2, P_PROC = 3'h3, P_STREAM = 3'h4
  } hfd_proc_t;

  typedef enum logic [1:0] {
    PH_DRIVE = 2'h0, PH_DISSIP = 2'h1, PH_BLANK = 2'h2, PH_ZC = 2'h3
  } hfd_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hfd_req_t;

  typedef struct packed {
    logic p;
    logic p_oe_n;
    logic n;
    logic n_oe_n;
  } hfd_bridge_t;

  localparam hfd_bridge_t BRIDGE_HIZ = '{p: 1'b0, p_oe_n: 1'b1, n: 1'b0, n_oe_n: 1'b1};

  typedef struct packed {
    logic go_bit;
    hfd_mode_t mode;
    logic [7:0] rated;
    logic [7:0] clamp;
    logic [4:0] drive_time;
    logic [3:0] idiss;
    logic [3:0] blank;
    logic [1:0] zc;
    logic linear_resonant_actuator;
    logic open_loop;
    logic [6:0] ol_period;
    logic oc_flag;
    hfd_proc_t proc;
    hfd_phase_t phase;
    logic [2:0] slot_idx;
    logic load_wait;
    logic [7:0] effect_id;
    logic [15:0] eff_cnt;
    logic [7:0] ph_cnt;
    logic [5:0] est;
    logic pol;
    logic fire_q;
    logic [15:0] prescale;
    logic [7:0] rdata;
    logic rd_slot;
    logic rvalid;
    logic adc_start;
    logic [7:0] level;
    hfd_bridge_t bridge;
  } hfd_state_t;

  localparam hfd_state_t STATE_RST = '{
    mode: MODE_INT_TRIG, proc: P_IDLE, phase: PH_DRIVE,
    rated: RST_RATED, clamp: RST_CLAMP, drive_time: RST_DRIVE_TIME,
    idiss: RST_IDISS, blank: RST_BLANK, zc: RST_ZC, linear_resonant_actuator: 1'b1,
    ol_period: RST_OL_PERIOD, bridge: BRIDGE_HIZ, default: '0};
endpackage : hfd_pkg
`default_nettype wire

// [src/hfd_slot_mem.sv]
`default_nettype none
module hfd_slot_mem #(
  parameter int W = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and clear
  input wire logic clock,
  input wire logic clear,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Two registered read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [W-1:0] q_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [W-1:0] q_b
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] qa;
    logic [W-1:0] qb;
  } hfd_mem_state_t;

  hfd_mem_state_t st_reg;
  hfd_mem_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (we)
    begin
      st_next.mem[waddr] = wdata;
    end
    st_next.qa = st_reg.mem[raddr_a];
    st_next.qb = st_reg.mem[raddr_b];
  end

  // Clear keeps empty slots meaning end of sequence
  always_ff @(posedge clock)
  begin
    if (clear)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q_a = st_reg.qa;
  assign q_b = st_reg.qb;
endmodule : hfd_slot_mem
`default_nettype wire

// [src/hfd_fire_drive.sv]
`default_nettype none
// Contract
// [R1] Fire signal starts playback of the eight sequencer slots, or calibration/diagnostics.
// [R2] Host writes one to the fire register to start internal-trigger playback.
// [R3] Fire bit stays set during playback; device clears it when sequence ends.
// [R4] Host clearing fire bit during playback cancels the remaining sequence.
// [R5] External trigger modes: trigger drives fire; fire bit mirrors trigger state.
// [R6] Streaming modes assert internal fire without changing the fire bit.
// [R7] Internal fire is fire bit OR streaming-mode selection.
// [R8] No load: closed loop toggles anyway; open loop toggles at configured period. Code toggles polarity in either loop only for the linear actuator.
// [R9] Regulator short shuts down; restart with all settings at defaults.
// [R10] Output short during a process sets overcurrent flag, held, current cut. Code holds the flag only while output_short stays high.
// [R11] Shorts only checked while a process runs; idle shorts wait for next attempt.
// [R12] Linear actuator: drive time seeds half-period estimate, then adapts.
// [R13] Rotating actuator: drive time sets back-EMF sampling rate.
// [R14] Dissipation interval from four-bit field precedes high-impedance sensing.
// [R15] Blanking interval from four-bit field precedes back-EMF conversion start.
// [R16] After blanking, watch zero crossings; two-bit field sets minimum time.
// [R17] Rated level sets steady drive in closed loop only.
// [R18] Open loop takes full-scale drive from the overdrive clamp register.
// [R19] Closed-loop overdrive and braking may exceed rated, never the clamp.
// [R20] Rated level above clamp is limited to the clamp.
// [R21] Host programs rated and clamp before calibration; recalibrates after changes.
// [R22] Mode field: 0..7 internal, edge, level, analog/PWM, audio, realtime, diag, cal.
module hfd_fire_drive #(
  parameter int TICK_CYCLES = hfd_pkg::TICK_CYCLES,
  parameter int EFFECT_TICKS = hfd_pkg::EFFECT_TICKS,
  parameter int OD_TICKS = hfd_pkg::OD_TICKS,
  parameter int PROC_TICKS = hfd_pkg::PROC_TICKS,
  parameter int ZC_WIN_TICKS = hfd_pkg::ZC_WIN_TICKS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port from the serial front end
  input wire hfd_pkg::hfd_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Trigger and sense inputs
  input wire logic trigger,
  input wire logic bemf_zero_cross,
  input wire logic output_short,
  input wire logic regulator_short,
  // Actuator side
  output hfd_pkg::hfd_bridge_t bridge,
  output logic [7:0] drive_level,
  output logic adc_start,
  // Status
  output logic [7:0] effect_id,
  output logic process_busy,
  output logic cal_active,
  output logic diag_active,
  output logic output_overcurrent_flag
);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] EFFECT_LAST = 16'(EFFECT_TICKS - 1);
  localparam logic [15:0] BRAKE_FIRST = 16'(EFFECT_TICKS - OD_TICKS);
  localparam logic [15:0] OD_END = 16'(OD_TICKS);
  localparam logic [15:0] PROC_LAST = 16'(PROC_TICKS - 1);
  localparam logic [7:0] ZC_WIN = 8'(ZC_WIN_TICKS);

  hfd_pkg::hfd_state_t st_reg;
  hfd_pkg::hfd_state_t st_next;
  logic [7:0] slot_q_host;
  logic [7:0] slot_q_seq;
  logic fire;
  logic stream_sel;
  logic ext_sel;
  logic tick;
  logic fire_wr;
  logic slot_wr;

  function automatic logic is_slot(input logic [7:0] a);
    is_slot = (a >= hfd_pkg::ADDR_SLOT_FIRST) && (a <= hfd_pkg::ADDR_SLOT_LAST);
  endfunction : is_slot

  function automatic logic drives(input hfd_pkg::hfd_proc_t p, input logic oc);
    drives = !oc && (p == hfd_pkg::P_PLAY || p == hfd_pkg::P_PROC || p == hfd_pkg::P_STREAM);
  endfunction : drives

  function automatic logic [7:0] reg_read(input hfd_pkg::hfd_state_t s, input logic [7:0] a);
    reg_read = 8'h00;
    unique case (a)
      hfd_pkg::ADDR_STATUS:
      begin
        reg_read[0] = s.oc_flag;
        reg_read[hfd_pkg::POS_BUSY] = (s.proc != hfd_pkg::P_IDLE);
      end
      hfd_pkg::ADDR_MODE: reg_read[2:0] = s.mode;
      hfd_pkg::ADDR_FIRE: reg_read[0] = s.go_bit;
      hfd_pkg::ADDR_RATED: reg_read = s.rated;
      hfd_pkg::ADDR_CLAMP: reg_read = s.clamp;
      hfd_pkg::ADDR_DRIVE_TIME: reg_read[4:0] = s.drive_time;
      hfd_pkg::ADDR_SENSE_TIME: reg_read = {s.blank, s.idiss};
      hfd_pkg::ADDR_LOOP_CFG:
      begin
        reg_read[1:0] = s.zc;
        reg_read[hfd_pkg::POS_OPEN_LOOP] = s.open_loop;
        reg_read[hfd_pkg::POS_LRA] = s.linear_resonant_actuator;
      end
      hfd_pkg::ADDR_OL_PERIOD: reg_read[6:0] = s.ol_period;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Mode decode
  assign stream_sel = (st_reg.mode == hfd_pkg::MODE_ANALOG_PWM) ||
                      (st_reg.mode == hfd_pkg::MODE_AUDIO_VIBE) ||
                      (st_reg.mode == hfd_pkg::MODE_REALTIME); // [R22] [R6]
  assign ext_sel = (st_reg.mode == hfd_pkg::MODE_EDGE_TRIG) ||
                   (st_reg.mode == hfd_pkg::MODE_LEVEL_TRIG); // [R22]
  assign fire = st_reg.go_bit | stream_sel; // [R7]
  assign tick = (st_reg.prescale == TICK_LAST);
  assign fire_wr = req.wr && (req.addr == hfd_pkg::ADDR_FIRE);
  assign slot_wr = req.wr && is_slot(req.addr);

  hfd_slot_mem #(
    .W(8),
    .DEPTH(8),
    .AW(3)
  ) u_slots (
    .clock(clock),
    .clear(!nrst || regulator_short),
    .we(slot_wr),
    .waddr(3'(req.addr - hfd_pkg::ADDR_SLOT_FIRST)),
    .wdata(req.wdata),
    .raddr_a(3'(req.addr - hfd_pkg::ADDR_SLOT_FIRST)),
    .q_a(slot_q_host),
    .raddr_b(st_reg.slot_idx),
    .q_b(slot_q_seq)
  );

  always_comb
  begin
    logic end_seq;
    logic [5:0] drive_len;
    logic [7:0] zc_min;
    logic [7:0] steady;
    end_seq = 1'b0;
    drive_len = st_reg.linear_resonant_actuator ? st_reg.est : 6'({1'b0, st_reg.drive_time} + 6'h01); // [R12] [R13]
    zc_min = 8'({6'h00, st_reg.zc} + 8'h01);
    steady = (st_reg.rated > st_reg.clamp) ? st_reg.clamp : st_reg.rated; // [R20]
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.adc_start = 1'b0;
    st_next.prescale = tick ? 16'h0000 : 16'(st_reg.prescale + 16'h0001);
    st_next.fire_q = fire;
    if (req.wr)
    begin
      unique case (req.addr)
        hfd_pkg::ADDR_MODE: st_next.mode = hfd_pkg::hfd_mode_t'(req.wdata[2:0]); // [R22]
        hfd_pkg::ADDR_FIRE: st_next.go_bit = req.wdata[0]; // [R2]
        hfd_pkg::ADDR_RATED: st_next.rated = req.wdata;
        hfd_pkg::ADDR_CLAMP: st_next.clamp = req.wdata;
        hfd_pkg::ADDR_DRIVE_TIME: st_next.drive_time = req.wdata[4:0];
        hfd_pkg::ADDR_SENSE_TIME:
        begin
          st_next.idiss = req.wdata[3:0];
          st_next.blank = req.wdata[hfd_pkg::POS_BLANK +: 4];
        end
        hfd_pkg::ADDR_LOOP_CFG:
        begin
          st_next.zc = req.wdata[1:0];
          st_next.open_loop = req.wdata[hfd_pkg::POS_OPEN_LOOP];
          st_next.linear_resonant_actuator = req.wdata[hfd_pkg::POS_LRA];
        end
        hfd_pkg::ADDR_OL_PERIOD: st_next.ol_period = req.wdata[6:0];
        default: st_next.go_bit = st_reg.go_bit;
      endcase
    end
    if (req.rd)
    begin
      st_next.rvalid = 1'b1;
      st_next.rd_slot = is_slot(req.addr);
      st_next.rdata = reg_read(st_reg, req.addr);
    end
    // External trigger overrides any software write
    if (ext_sel)
    begin
      st_next.go_bit = trigger; // [R5]
    end
    unique case (st_reg.proc)
      hfd_pkg::P_IDLE:
      begin
        if (fire && !st_reg.fire_q && !st_reg.oc_flag) // [R1]
        begin
          st_next.slot_idx = 3'h0;
          st_next.load_wait = 1'b1;
          st_next.eff_cnt = 16'h0000;
          st_next.ph_cnt = 8'h00;
          st_next.phase = hfd_pkg::PH_DRIVE;
          st_next.pol = 1'b0;
          st_next.est = 6'({1'b0, st_reg.drive_time} + 6'h01); // [R12]
          if (stream_sel)
          begin
            st_next.proc = hfd_pkg::P_STREAM; // [R6]
          end
          else if (st_reg.mode == hfd_pkg::MODE_DIAG || st_reg.mode == hfd_pkg::MODE_CAL)
          begin
            st_next.proc = hfd_pkg::P_PROC; // [R1]
          end
          else
          begin
            st_next.proc = hfd_pkg::P_LOAD; // [R1]
          end
        end
      end
      hfd_pkg::P_LOAD:
      begin
        // Slot memory read is registered: wait one cycle for data
        if (st_reg.load_wait)
        begin
          st_next.load_wait = 1'b0;
        end
        else if (slot_q_seq == 8'h00)
        begin
          end_seq = 1'b1;
        end
        else
        begin
          st_next.effect_id = slot_q_seq;
          st_next.eff_cnt = 16'h0000;
          st_next.proc = hfd_pkg::P_PLAY;
        end
      end
      hfd_pkg::P_PLAY:
      begin
        if (tick && st_reg.eff_cnt == EFFECT_LAST)
        begin
          if (st_reg.slot_idx == 3'h7)
          begin
            end_seq = 1'b1;
          end
          else
          begin
            st_next.slot_idx = 3'(st_reg.slot_idx + 3'h1);
            st_next.load_wait = 1'b1;
            st_next.proc = hfd_pkg::P_LOAD;
          end
        end
        else if (tick)
        begin
          st_next.eff_cnt = 16'(st_reg.eff_cnt + 16'h0001);
        end
      end
      hfd_pkg::P_PROC:
      begin
        if (tick && st_reg.eff_cnt == PROC_LAST)
        begin
          end_seq = 1'b1;
        end
        else if (tick)
        begin
          st_next.eff_cnt = 16'(st_reg.eff_cnt + 16'h0001);
        end
      end
      hfd_pkg::P_STREAM:
      begin
        st_next.proc = hfd_pkg::P_STREAM;
      end
      default: st_next.proc = hfd_pkg::P_IDLE;
    endcase
    if (end_seq)
    begin
      st_next.proc = hfd_pkg::P_IDLE;
      st_next.effect_id = 8'h00;
      // A fresh host write of the fire bit wins over the self-clear
      if (!ext_sel && !fire_wr)
      begin
        st_next.go_bit = 1'b0; // [R3]
      end
    end
    // Edge trigger plays to the end once started
    if (!fire && st_reg.proc != hfd_pkg::P_IDLE && st_reg.mode != hfd_pkg::MODE_EDGE_TRIG)
    begin
      st_next.proc = hfd_pkg::P_IDLE; // [R4]
      st_next.effect_id = 8'h00;
    end
    // Only a running process can see the short
    st_next.oc_flag = output_short && (st_reg.oc_flag || st_reg.proc != hfd_pkg::P_IDLE); // [R11]
    if (output_short && st_reg.proc != hfd_pkg::P_IDLE)
    begin
      st_next.proc = hfd_pkg::P_IDLE; // [R10]
      st_next.effect_id = 8'h00;
      if (!ext_sel)
      begin
        st_next.go_bit = 1'b0;
      end
    end
    if (!drives(st_reg.proc, st_reg.oc_flag))
    begin
      st_next.phase = hfd_pkg::PH_DRIVE;
      st_next.ph_cnt = 8'h00;
    end
    else if (st_reg.open_loop)
    begin
      st_next.phase = hfd_pkg::PH_DRIVE;
      if (tick && st_reg.ph_cnt == {1'b0, st_reg.ol_period})
      begin
        st_next.ph_cnt = 8'h00;
        st_next.pol = st_reg.linear_resonant_actuator ? !st_reg.pol : st_reg.pol; // [R8]
      end
      else if (tick)
      begin
        st_next.ph_cnt = 8'(st_reg.ph_cnt + 8'h01);
      end
    end
    else if (tick)
    begin
      st_next.ph_cnt = 8'(st_reg.ph_cnt + 8'h01);
      unique case (st_reg.phase)
        hfd_pkg::PH_DRIVE:
        begin
          if (8'(st_reg.ph_cnt + 8'h01) == {2'b00, drive_len}) // [R12] [R13]
          begin
            st_next.phase = hfd_pkg::PH_DISSIP;
            st_next.ph_cnt = 8'h00;
          end
        end
        hfd_pkg::PH_DISSIP:
        begin
          if (st_reg.ph_cnt == {4'h0, st_reg.idiss}) // [R14]
          begin
            st_next.phase = hfd_pkg::PH_BLANK;
            st_next.ph_cnt = 8'h00;
          end
        end
        hfd_pkg::PH_BLANK:
        begin
          if (st_reg.ph_cnt == {4'h0, st_reg.blank}) // [R15]
          begin
            st_next.adc_start = 1'b1;
            st_next.ph_cnt = 8'h00;
            // Rotating actuator only samples, then drives again
            st_next.phase = st_reg.linear_resonant_actuator ? hfd_pkg::PH_ZC : hfd_pkg::PH_DRIVE; // [R13]
          end
        end
        hfd_pkg::PH_ZC:
        begin
          // No crossing: lengthen estimate; keeps toggling with no load
          if (st_reg.ph_cnt == 8'(zc_min + ZC_WIN))
          begin
            st_next.phase = hfd_pkg::PH_DRIVE;
            st_next.ph_cnt = 8'h00;
            st_next.pol = !st_reg.pol; // [R8]
            st_next.est = (st_reg.est == 6'h3F) ? st_reg.est : 6'(st_reg.est + 6'h01); // [R12]
          end
        end
      endcase
    end
    if (drives(st_reg.proc, st_reg.oc_flag) && !st_reg.open_loop &&
        st_reg.phase == hfd_pkg::PH_ZC && bemf_zero_cross && st_reg.ph_cnt >= zc_min) // [R16]
    begin
      st_next.phase = hfd_pkg::PH_DRIVE;
      st_next.ph_cnt = 8'h00;
      st_next.pol = !st_reg.pol;
      if (st_reg.ph_cnt == zc_min && st_reg.est > 6'h01)
      begin
        st_next.est = 6'(st_reg.est - 6'h01); // [R12]
      end
    end
    st_next.bridge = hfd_pkg::BRIDGE_HIZ;
    st_next.level = 8'h00;
    if (drives(st_next.proc, st_next.oc_flag) && st_next.phase == hfd_pkg::PH_DRIVE)
    begin
      st_next.bridge = '{p: !st_next.pol, p_oe_n: 1'b0, n: st_next.pol, n_oe_n: 1'b0};
      if (st_next.open_loop)
      begin
        st_next.level = st_next.clamp; // [R18]
      end
      else if (st_next.proc == hfd_pkg::P_PLAY &&
               (st_next.eff_cnt < OD_END || st_next.eff_cnt >= BRAKE_FIRST))
      begin
        st_next.level = st_next.clamp; // [R19]
      end
      else
      begin
        st_next.level = (st_next.rated > st_next.clamp) ? st_next.clamp : st_next.rated; // [R17]
      end
    end
    else if (drives(st_next.proc, st_next.oc_flag) && st_next.phase == hfd_pkg::PH_DISSIP)
    begin
      st_next.bridge = '{p: 1'b0, p_oe_n: 1'b0, n: 1'b0, n_oe_n: 1'b0}; // [R14]
    end
    if (steady > st_reg.clamp)
    begin
      st_next.level = 8'h00;
    end
  end

  // Regulator short holds everything at defaults until removed
  always_ff @(posedge clock)
  begin
    if (!nrst || regulator_short) // [R9]
    begin
      st_reg <= hfd_pkg::STATE_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rd_slot ? slot_q_host : st_reg.rdata;
  assign rvalid = st_reg.rvalid;
  assign bridge = st_reg.bridge;
  assign drive_level = st_reg.level;
  assign adc_start = st_reg.adc_start;
  assign effect_id = st_reg.effect_id;
  assign process_busy = (st_reg.proc != hfd_pkg::P_IDLE);
  assign cal_active = (st_reg.proc == hfd_pkg::P_PROC) && (st_reg.mode == hfd_pkg::MODE_CAL);
  assign diag_active = (st_reg.proc == hfd_pkg::P_PROC) && (st_reg.mode == hfd_pkg::MODE_DIAG);
  assign output_overcurrent_flag = st_reg.oc_flag;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst || regulator_short);

  sequence s_clear_fire;
    fire_wr && !req.wdata[0] && st_reg.mode == hfd_pkg::MODE_INT_TRIG;
  endsequence
  sequence s_idle_within_two;
    ##1 !st_reg.go_bit ##1 st_reg.proc == hfd_pkg::P_IDLE;
  endsequence

  AST_FIRE_START: assert property ( // [R1]
    st_reg.proc == hfd_pkg::P_IDLE && fire && !st_reg.fire_q && !st_reg.oc_flag &&
    st_reg.mode == hfd_pkg::MODE_INT_TRIG && !output_short && !req.wr
    |=> st_reg.proc == hfd_pkg::P_LOAD ##2 st_reg.proc != hfd_pkg::P_LOAD)
    else $error("Fire did not start slot loading");
  AST_GO_HELD: assert property ( // [R3]
    st_reg.mode == hfd_pkg::MODE_INT_TRIG && st_reg.proc == hfd_pkg::P_PLAY && !req.wr
    |=> st_reg.go_bit || st_reg.proc == hfd_pkg::P_IDLE)
    else $error("Fire bit dropped while playing");
  AST_CANCEL: assert property ( // [R4]
    (st_reg.proc == hfd_pkg::P_PLAY && !(req.wr && req.addr == hfd_pkg::ADDR_MODE))
    and s_clear_fire |-> s_idle_within_two)
    else $error("Clearing fire bit did not cancel playback");
  AST_MIRROR: assert property ( // [R5]
    ext_sel && !(req.wr && req.addr == hfd_pkg::ADDR_MODE) |=> st_reg.go_bit == $past(trigger))
    else $error("Fire bit does not mirror trigger");
  AST_STREAM_BIT: assert property ( // [R6]
    stream_sel && !req.wr |-> fire ##1 $stable(st_reg.go_bit))
    else $error("Streaming mode disturbed fire bit");
  AST_OC_SET: assert property ( // [R10]
    st_reg.proc != hfd_pkg::P_IDLE && output_short
    |=> st_reg.oc_flag && st_reg.bridge == hfd_pkg::BRIDGE_HIZ && drive_level == 8'h00)
    else $error("Output short not flagged or current not cut");
  AST_OC_IDLE: assert property ( // [R11]
    st_reg.proc == hfd_pkg::P_IDLE && !st_reg.oc_flag |=> !st_reg.oc_flag)
    else $error("Short detected while idle");
  AST_CLAMP_BOUND: assert property ( // [R19] [R20]
    drive_level <= st_reg.clamp)
    else $error("Drive level above clamp");
  AST_OPEN_LEVEL: assert property ( // [R18]
    st_reg.open_loop && drive_level != 8'h00 |-> drive_level == st_reg.clamp)
    else $error("Open loop level is not the clamp");
  AST_DISSIP_LOW: assert property ( // [R14]
    st_reg.phase == hfd_pkg::PH_DISSIP && drives(st_reg.proc, st_reg.oc_flag)
    |-> !bridge.p_oe_n && !bridge.n_oe_n && !bridge.p && !bridge.n ##0 drive_level == 8'h00)
    else $error("Dissipation phase not driving both outputs low");
  AST_BLANK_ADC: assert property ( // [R15]
    $rose(adc_start) |-> $past(st_reg.phase) == hfd_pkg::PH_BLANK)
    else $error("Conversion started outside blanking end");
endmodule : hfd_fire_drive
`default_nettype wire

// [verif/hfd_act_model.sv]
`default_nettype none
module hfd_act_model (
  // Clock
  input wire logic clock,
  // Bridge from the driver
  input wire hfd_pkg::hfd_bridge_t bridge,
  // Fault command from the bench
  input wire logic short_cmd,
  // Sense back to the driver
  output logic bemf_zero_cross,
  output logic output_short
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_reg = 3'h0;
  logic bemf_reg = 1'b0;
  always_ff @(posedge clock)
  begin
    // Back-EMF only seen once both outputs are released
    if (bridge.p_oe_n && bridge.n_oe_n)
    begin
      cnt_reg <= cnt_reg + 3'h1;
    end
    else
    begin
      cnt_reg <= 3'h0;
    end
    bemf_reg <= (cnt_reg == 3'h5);
  end
  assign bemf_zero_cross = bemf_reg;
  // Load fault shown as a plain level
  assign output_short = short_cmd;
endmodule : hfd_act_model
`default_nettype wire

// [verif/tb_haptic_fire_trigger_and_drive_timing.sv]
`default_nettype none
module tb_haptic_fire_trigger_and_drive_timing;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst, trigger, short_cmd, reg_short, zc, osh, busy, flag;
  hfd_pkg::hfd_req_t req;
  hfd_pkg::hfd_bridge_t bridge;
  logic [7:0] rdata, v;
  logic rvalid;
  logic [7:0] lvl, eid, n0;
  logic [7:0] adc_n = 8'h00;
  logic adc, cal, diag;
  int errors = 0, samples_checked = 0, cycles = 0;
  always #5 clock = ~clock;
  hfd_fire_drive #(.TICK_CYCLES(4), .EFFECT_TICKS(6), .OD_TICKS(1), .PROC_TICKS(8),
    .ZC_WIN_TICKS(2)) uut (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .trigger(trigger), .bemf_zero_cross(zc), .output_short(osh),
    .regulator_short(reg_short), .bridge(bridge), .drive_level(lvl), .adc_start(adc),
    .effect_id(eid), .process_busy(busy), .cal_active(cal), .diag_active(diag),
    .output_overcurrent_flag(flag));
  hfd_act_model act (.clock(clock), .bridge(bridge), .short_cmd(short_cmd),
    .bemf_zero_cross(zc), .output_short(osh));
  task finish_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Steady level is rated, bounded by the clamp
  function automatic logic [7:0] exp_level(input logic [7:0] r, input logic [7:0] c);
    exp_level = (r > c) ? c : r;
  endfunction : exp_level
  always @(posedge clock)
    if (adc)
      adc_n <= 8'(adc_n + 8'h01);
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock) req = '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock) req = '0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask : rd
  task wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(negedge clock);
  endtask : wait_idle
  // Hang guard, well above the longest sequence
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      errors++;
      finish_test;
    end
  end
  initial
  begin
    req = '0; trigger = 0; short_cmd = 0; reg_short = 0; nrst = 0;
    void'($urandom(72));
    repeat (5) @(negedge clock);
    nrst = 1;
    rd(hfd_pkg::ADDR_RATED, 8'h3F);
    rd(hfd_pkg::ADDR_CLAMP, 8'h8C);
    rd(hfd_pkg::ADDR_FIRE, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      wr(hfd_pkg::ADDR_RATED, v);
      rd(hfd_pkg::ADDR_RATED, v);
    end
    wr(hfd_pkg::ADDR_CLAMP, 8'hC8);
    wr(8'h04, 8'h11);
    wr(8'h05, 8'h22);
    wr(hfd_pkg::ADDR_FIRE, 8'h01);
    repeat (3) @(negedge clock);
    chk({7'h00, busy}, 8'h01);
    chk(eid, 8'h11);
    chk(lvl, 8'hC8);
    repeat (9) @(negedge clock);
    chk(lvl, exp_level(v, 8'hC8));
    rd(hfd_pkg::ADDR_FIRE, 8'h01);
    wait_idle;
    rd(hfd_pkg::ADDR_FIRE, 8'h00);
    wr(hfd_pkg::ADDR_FIRE, 8'h01);
    repeat (6) @(negedge clock);
    wr(hfd_pkg::ADDR_FIRE, 8'h00);
    repeat (2) @(negedge clock);
    chk({7'h00, busy}, 8'h00);
    wr(hfd_pkg::ADDR_MODE, 8'h02);
    trigger = 1;
    repeat (3) @(negedge clock);
    rd(hfd_pkg::ADDR_FIRE, 8'h01);
    chk({7'h00, busy}, 8'h01);
    trigger = 0;
    repeat (3) @(negedge clock);
    rd(hfd_pkg::ADDR_FIRE, 8'h00);
    wr(hfd_pkg::ADDR_MODE, 8'h01);
    trigger = 1;
    repeat (3) @(negedge clock);
    trigger = 0;
    repeat (3) @(negedge clock);
    chk({7'h00, busy}, 8'h01);
    wait_idle;
    wr(hfd_pkg::ADDR_MODE, 8'h05);
    repeat (3) @(negedge clock);
    chk({7'h00, busy}, 8'h01);
    rd(hfd_pkg::ADDR_FIRE, 8'h00);
    wr(hfd_pkg::ADDR_MODE, 8'h00);
    wait_idle;
    for (int m = 6; m < 8; m++)
    begin
      wr(hfd_pkg::ADDR_MODE, 8'(m));
      wr(hfd_pkg::ADDR_FIRE, 8'h01);
      repeat (3) @(negedge clock);
      chk({6'h00, diag, cal}, (m == 6) ? 8'h02 : 8'h01);
      wait_idle;
      rd(hfd_pkg::ADDR_FIRE, 8'h00);
    end
    wr(hfd_pkg::ADDR_MODE, 8'h00);
    wr(hfd_pkg::ADDR_DRIVE_TIME, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      n0 = adc_n;
      wr(hfd_pkg::ADDR_LOOP_CFG, k ? 8'h01 : 8'h81);
      wr(hfd_pkg::ADDR_FIRE, 8'h01);
      repeat (3) @(negedge clock);
      wait_idle;
      chk({7'h00, adc_n != n0}, 8'h01);
    end
    wr(hfd_pkg::ADDR_RATED, 8'h20);
    wr(hfd_pkg::ADDR_LOOP_CFG, 8'hA1);
    wr(hfd_pkg::ADDR_FIRE, 8'h01);
    repeat (12) @(negedge clock);
    chk(lvl, 8'hC8);
    wait_idle;
    short_cmd = 1;
    repeat (3) @(negedge clock);
    chk({7'h00, flag}, 8'h00);
    wr(hfd_pkg::ADDR_FIRE, 8'h01);
    repeat (3) @(negedge clock);
    chk({7'h00, flag}, 8'h01);
    chk({6'h00, bridge.p_oe_n, bridge.n_oe_n}, 8'h03);
    short_cmd = 0;
    repeat (3) @(negedge clock);
    chk({7'h00, flag}, 8'h00);
    wr(hfd_pkg::ADDR_RATED, 8'h55);
    reg_short = 1;
    @(negedge clock) reg_short = 0;
    rd(hfd_pkg::ADDR_RATED, 8'h3F);
    finish_test;
  end
endmodule : tb_haptic_fire_trigger_and_drive_timing
`default_nettype wire
